// ---- common/reset_init_consts.svh ----
// Constants for the reset and initialization state sequencer
`ifndef RESET_INIT_CONSTS_SVH
`define RESET_INIT_CONSTS_SVH
`define REG_ADDR_W 8
`define MULT_W 4
`define ST_GROUPS 4
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CR0 8'h08
`define REG_ACC 8'h0C
`define REG_IDENT 8'h10
`define REG_FPU_CWSW 8'h14
`define REG_FPU_TAG 8'h18
`define REG_SYSTEM_MGMT_BASE_ADDRESS 8'h1C
`define REG_CS_SEL 8'h20
`define REG_CS_BASE 8'h24
`define REG_RIP 8'h28
`define REG_FLAGS 8'h2C
`define REG_DBG_STAT 8'h30
`define REG_DBG_CTRL 8'h34
`define REG_MEDIA_CSR 8'h38
`define REG_TSC_LO 8'h3C
`define REG_TSC_HI 8'h40
`define REG_ATTR_CD 8'h44
`define REG_ATTR_LT 8'h48
`define REG_TPR 8'h4C
`define REG_WIN_SEL 8'h50
`define REG_WIN_DATA 8'h54
`define CTRL_ST_EN 0
`define CTRL_MULT_OVR 1
`define CTRL_MULT_LSB 4
`define CTRL_SOFT_BIT 8
`define WIN_FPR 6'h10
`define WIN_XMM 6'h18
`define WIN_DR 6'h28
`define WIN_CR2 6'h2C
`define WIN_CR3 6'h2D
`define WIN_CR4 6'h2E
`define WIN_EXTENDED_FEATURE_REG 6'h2F
`define WIN_FIP 6'h30
`define WIN_FDP 6'h31
`define WIN_FSEL 6'h32
`define WIN_FOP 6'h33
`define CR0_HW_RESET 64'h0000_0000_6000_0010
`define CR0_KEEP_MASK 64'h0000_0000_6000_0000
`define CR0_SOFT_SET 64'h0000_0000_0000_0010
`define FLAGS_RESET 64'h0000_0000_0000_0002
`define RIP_RESET 64'h0000_0000_0000_FFF0
`define DR6_RESET 64'h0000_0000_FFFF_0FF0
`define DR7_RESET 64'h0000_0000_0000_0400
`define FPU_CW_RESET 16'h0040
`define FPU_SW_RESET 16'h0000
`define FPU_TAG_RESET 16'h5555
`define MEDIA_CONTROL_STATUS_REG_RESET 32'h0000_1F80
`define SYSTEM_MGMT_BASE_ADDRESS_RESET 32'h0003_0000
`define CS_SEL_RESET 16'hF000
`define CS_BASE_RESET 64'h0000_0000_FFFF_0000
`define ATTR_CODE 11'h09A
`define ATTR_DATA 11'h092
`define ATTR_LDT 11'h082
`define ATTR_TSS 11'h083
`define IDX_ACC 4'h0
`define IDX_IDENT 4'h2
`endif

// ---- common/reset_init_pkg.sv ----
// Types for the reset and initialization state sequencer
package reset_init_pkg;
`include "reset_init_consts.svh"
	typedef logic [1:0] axi_resp_t;
	localparam axi_resp_t RESP_OKAY = 2'h0;
	localparam axi_resp_t RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_HW_RESET, ST_SELFTEST, ST_RUN} seq_e;
	typedef struct packed {
		logic busy;
		logic done;
		logic [1:0] group;
		logic [31:0] cnt;
		logic [`ST_GROUPS-1:0] fail;
	} engine_state_s;
	typedef struct packed {
		seq_e seq;
		logic hw_s1, hw_s2, init_s1, init_s2, init_prev;
		logic [`MULT_W-1:0] mult_s1, mult_s2, mult_strap, core_mult, ctrl_mult;
		logic [`ST_GROUPS-1:0] fault_s1, fault_s2;
		logic ctrl_st_en, ctrl_mult_ovr, st_ran, last_hw, apic_en, cache_inv, tlb_inv;
		logic [63:0] cr0, cr2, cr3, cr4, tpr, flags, extended_feature_reg, instruction_pointer;
		logic [15:0][63:0] gpr;
		logic [15:0] fpu_cw, fpu_sw, fpu_tag, fpu_cs, fpu_ds;
		logic [10:0] fpu_op;
		logic [63:0] fpu_ip, fpu_dp;
		logic [7:0][79:0] fpr;
		logic [15:0][127:0] xmm;
		logic [31:0] media_control_status_reg, system_mgmt_base_address;
		logic [3:0][63:0] dr;
		logic [63:0] dr6, dr7, tsc, cs_base;
		logic [15:0] cs_sel;
		logic [10:0] attr_code, attr_data, attr_ldt, attr_tss;
		logic aw_have, w_have, bvalid, rvalid;
		logic [`REG_ADDR_W-1:0] awaddr;
		logic [31:0] wdata, rdata;
		logic [3:0] wstrb;
		axi_resp_t bresp, rresp;
		logic [5:0] win_sel;
	} top_state_s;
endpackage

// ---- common/selftest_if.sv ----
// Link between the sequencer and the self-test engine
`timescale 1ns/100ps
interface selftest_if;
	logic                  start;
	logic                  abort;
	logic [3:0]            fault;
	logic                  busy;
	logic                  done;
	logic [3:0]            fail;
	modport engine (input start, input abort, input fault, output busy, output done, output fail);
	modport ctrl (output start, output abort, output fault, input busy, input done, input fail);
endinterface

// ---- hw/self_test_engine.sv ----
// Self-test engine walking the internal array groups
`timescale 1ns/100ps
module self_test_engine #(
	parameter int GROUP_CYCLES = 1000000
) (
	input  wire logic      aclk,
	input  wire logic      aresetn,
	input  wire logic      ce,
	selftest_if.engine     st
);
	import reset_init_pkg::*;
	engine_state_s s;
	engine_state_s n;

	assign st.busy = s.busy;
	assign st.done = s.done;
	assign st.fail = s.fail;

	// Groups: 0 caches tag/data, 1 translation buffers, 2 internal ROMs, 3 branch prediction
	always_comb
	begin
		n = s;
		n.done = 1'b0;
		if (st.abort)
		begin
			n.busy = 1'b0;
			n.cnt = 32'h0;
		end
		else if (st.start && !s.busy)
		begin
			n.busy = 1'b1;
			n.group = 2'h0;
			n.cnt = 32'h0;
			n.fail = '0;
		end
		else if (s.busy)
		begin
			if (st.fault[s.group])
				n.fail[s.group] = 1'b1;
			if (s.cnt == 32'(GROUP_CYCLES - 1))
			begin
				n.cnt = 32'h0;
				if (s.group == 2'(`ST_GROUPS - 1))
				begin
					n.busy = 1'b0;
					n.done = 1'b1;
				end
				else
					n.group = s.group + 2'h1;
			end
			else
				n.cnt = s.cnt + 32'h1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else if (ce)
			s <= n;
	end
endmodule

// ---- hw/processor_reset_init_state.sv ----
// Reset and soft-initialization state sequencer with register access
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module processor_reset_init_state #(
	parameter int         GROUP_CYCLES = 1000000,
	parameter bit         SELFTEST_DEFAULT = 1'b1,
	parameter logic [7:0] EXT_FAMILY = 8'h01,
	parameter logic [3:0] EXT_MODEL = 4'h2,
	parameter logic [3:0] FAMILY = 4'h3,
	parameter logic [3:0] MODEL = 4'h4,
	parameter logic [3:0] STEPPING = 4'h5
) (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic                         ce,
	input  wire logic                         hw_reset_n,
	input  wire logic                         soft_init_req,
	input  wire logic [`MULT_W-1:0]           clk_mult_strap,
	input  wire logic [`ST_GROUPS-1:0]        array_fault,
	input  wire logic [`REG_ADDR_W-1:0]       awaddr,
	input  wire logic [2:0]                   awprot,
	input  wire logic                         awvalid,
	output logic                              awready,
	input  wire logic [31:0]                  wdata,
	input  wire logic [3:0]                   wstrb,
	input  wire logic                         wvalid,
	output logic                              wready,
	output reset_init_pkg::axi_resp_t         bresp,
	output logic                              bvalid,
	input  wire logic                         bready,
	input  wire logic [`REG_ADDR_W-1:0]       araddr,
	input  wire logic [2:0]                   arprot,
	input  wire logic                         arvalid,
	output logic                              arready,
	output logic [31:0]                       rdata,
	output reset_init_pkg::axi_resp_t         rresp,
	output logic                              rvalid,
	input  wire logic                         rready,
	output logic [`MULT_W-1:0]                core_clk_mult,
	output logic                              init_busy,
	output logic                              selftest_running,
	output logic                              cache_invalidate,
	output logic                              tlb_invalidate,
	output logic                              apic_enable
);
	import reset_init_pkg::*;

	// Identification values are arbitrary
	localparam logic [63:0] IDENT_VALUE = {32'h0, 4'h0, EXT_FAMILY, EXT_MODEL, 4'h0,
		FAMILY, MODEL, STEPPING};

	top_state_s s;
	top_state_s n;
	logic       soft_go;
	logic       soft_edge;
	logic       ar_take;
	logic [7:0] wa;
	selftest_if st_bus ();

	self_test_engine #(
		.GROUP_CYCLES (GROUP_CYCLES)
	) u_engine (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.st      (st_bus.engine)
	);

	assign st_bus.start = (s.seq == ST_HW_RESET) && s.hw_s2 && s.ctrl_st_en;
	assign st_bus.abort = !s.hw_s2;
	assign st_bus.fault = s.fault_s2;

	assign awready = !s.aw_have && !s.bvalid;
	assign wready = !s.w_have && !s.bvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = !s.rvalid;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign core_clk_mult = s.core_mult;
	assign init_busy = (s.seq != ST_RUN);
	assign selftest_running = (s.seq == ST_SELFTEST);
	assign cache_invalidate = s.cache_inv;
	assign tlb_invalidate = s.tlb_inv;
	assign apic_enable = s.apic_en;

	function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	// State common to both reset kinds
	function automatic top_state_s common_init(input top_state_s t);
		top_state_s r;
		r = t;
		r.cr2 = 64'h0;
		r.cr3 = 64'h0;
		r.cr4 = 64'h0;
		r.extended_feature_reg = 64'h0;
		r.flags = `FLAGS_RESET;
		r.instruction_pointer = `RIP_RESET;
		r.gpr = '0;
		r.gpr[`IDX_IDENT] = IDENT_VALUE;
		r.dr = '0;
		r.dr6 = `DR6_RESET;
		r.dr7 = `DR7_RESET;
		r.cs_sel = `CS_SEL_RESET;
		r.cs_base = `CS_BASE_RESET;
		r.attr_code = `ATTR_CODE;
		r.attr_data = `ATTR_DATA;
		r.attr_ldt = `ATTR_LDT;
		r.attr_tss = `ATTR_TSS;
		return r;
	endfunction

	function automatic top_state_s hw_init(input top_state_s t);
		top_state_s r;
		r = common_init(t);
		r.cr0 = `CR0_HW_RESET;
		r.tpr = 64'h0;
		r.fpu_cw = `FPU_CW_RESET;
		r.fpu_sw = `FPU_SW_RESET;
		r.fpu_tag = `FPU_TAG_RESET;
		r.fpr = '0;
		r.fpu_cs = 16'h0;
		r.fpu_ds = 16'h0;
		r.fpu_ip = 64'h0;
		r.fpu_dp = 64'h0;
		r.fpu_op = 11'h0;
		r.xmm = '0;
		r.media_control_status_reg = `MEDIA_CONTROL_STATUS_REG_RESET;
		r.tsc = 64'h0;
		r.system_mgmt_base_address = `SYSTEM_MGMT_BASE_ADDRESS_RESET;
		r.apic_en = 1'b1;
		r.st_ran = 1'b0;
		r.last_hw = 1'b1;
		return r;
	endfunction

	function automatic top_state_s soft_init(input top_state_s t);
		top_state_s r;
		r = common_init(t);
		r.cr0 = (t.cr0 & `CR0_KEEP_MASK) | `CR0_SOFT_SET;
		r.last_hw = 1'b0;
		return r;
	endfunction

	function automatic top_state_s reset_state();
		top_state_s r;
		r = hw_init('0);
		r.seq = ST_HW_RESET;
		r.ctrl_st_en = SELFTEST_DEFAULT;
		return r;
	endfunction

	function automatic logic [31:0] win_read(input top_state_s t);
		logic [5:0] k;
		logic [31:0] v;
		k = t.win_sel;
		v = 32'h0;
		if (k < `WIN_FPR)
			v = t.gpr[k[3:0]][31:0];
		else if (k < `WIN_XMM)
			v = t.fpr[3'(k - `WIN_FPR)][31:0];
		else if (k < `WIN_DR)
			v = t.xmm[4'(k - `WIN_XMM)][31:0];
		else if (k < `WIN_CR2)
			v = t.dr[2'(k - `WIN_DR)][31:0];
		else if (k == `WIN_CR2)
			v = t.cr2[31:0];
		else if (k == `WIN_CR3)
			v = t.cr3[31:0];
		else if (k == `WIN_CR4)
			v = t.cr4[31:0];
		else if (k == `WIN_EXTENDED_FEATURE_REG)
			v = t.extended_feature_reg[31:0];
		else if (k == `WIN_FIP)
			v = t.fpu_ip[31:0];
		else if (k == `WIN_FDP)
			v = t.fpu_dp[31:0];
		else if (k == `WIN_FSEL)
			v = {t.fpu_cs, t.fpu_ds};
		else if (k == `WIN_FOP)
			v = {21'h0, t.fpu_op};
		return v;
	endfunction

	function automatic logic [31:0] ctrl_read(input top_state_s t);
		logic [31:0] v;
		v = 32'h0;
		v[`CTRL_ST_EN] = t.ctrl_st_en;
		v[`CTRL_MULT_OVR] = t.ctrl_mult_ovr;
		v[`CTRL_MULT_LSB +: `MULT_W] = t.ctrl_mult;
		return v;
	endfunction

	function automatic logic [32:0] reg_read(input top_state_s t, input logic [7:0] a);
		logic [31:0] v;
		logic        hit;
		v = 32'h0;
		hit = 1'b1;
		unique case (a)
			`REG_CTRL: v = ctrl_read(t);
			`REG_STATUS: v = {20'h0, t.core_mult, 3'h0, t.apic_en, t.last_hw, t.st_ran,
				t.seq == ST_SELFTEST, t.seq != ST_RUN};
			`REG_CR0: v = t.cr0[31:0];
			`REG_ACC: v = t.gpr[`IDX_ACC][31:0];
			`REG_IDENT: v = t.gpr[`IDX_IDENT][31:0];
			`REG_FPU_CWSW: v = {t.fpu_sw, t.fpu_cw};
			`REG_FPU_TAG: v = {16'h0, t.fpu_tag};
			`REG_SYSTEM_MGMT_BASE_ADDRESS: v = t.system_mgmt_base_address;
			`REG_CS_SEL: v = {16'h0, t.cs_sel};
			`REG_CS_BASE: v = t.cs_base[31:0];
			`REG_RIP: v = t.instruction_pointer[31:0];
			`REG_FLAGS: v = t.flags[31:0];
			`REG_DBG_STAT: v = t.dr6[31:0];
			`REG_DBG_CTRL: v = t.dr7[31:0];
			`REG_MEDIA_CSR: v = t.media_control_status_reg;
			`REG_TSC_LO: v = t.tsc[31:0];
			`REG_TSC_HI: v = t.tsc[63:32];
			`REG_ATTR_CD: v = {5'h0, t.attr_data, 5'h0, t.attr_code};
			`REG_ATTR_LT: v = {5'h0, t.attr_tss, 5'h0, t.attr_ldt};
			`REG_TPR: v = t.tpr[31:0];
			`REG_WIN_SEL: v = {26'h0, t.win_sel};
			`REG_WIN_DATA: v = win_read(t);
			default: hit = 1'b0;
		endcase
		return {hit, v};
	endfunction

	assign soft_edge = s.init_s2 && !s.init_prev;
	assign ar_take = arvalid && !s.rvalid;
	assign wa = {s.awaddr[7:2], 2'h0};

	always_comb
	begin
		logic [32:0] rd;
		logic [31:0] m;
		logic [5:0]  k;
		rd = 33'h0;
		m = 32'h0;
		k = s.win_sel;
		soft_go = 1'b0;
		n = s;
		n.cache_inv = 1'b0;
		n.tlb_inv = 1'b0;
		n.hw_s1 = hw_reset_n;
		n.hw_s2 = s.hw_s1;
		n.init_s1 = soft_init_req;
		n.init_s2 = s.init_s1;
		n.init_prev = s.init_s2;
		n.mult_s1 = clk_mult_strap;
		n.mult_s2 = s.mult_s1;
		n.fault_s1 = array_fault;
		n.fault_s2 = s.fault_s1;
		n.tsc = s.tsc + 64'h1;
		n.core_mult = s.ctrl_mult_ovr ? s.ctrl_mult : s.mult_strap;
		if (awvalid && awready)
		begin
			n.aw_have = 1'b1;
			n.awaddr = awaddr;
		end
		if (wvalid && wready)
		begin
			n.w_have = 1'b1;
			n.wdata = wdata;
			n.wstrb = wstrb;
		end
		if (s.bvalid && bready)
			n.bvalid = 1'b0;
		if (s.aw_have && s.w_have)
		begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			rd = reg_read(s, wa);
			n.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
			case (wa)
				`REG_CTRL:
				begin
					m = merge32(ctrl_read(s), s.wdata, s.wstrb);
					n.ctrl_st_en = m[`CTRL_ST_EN];
					n.ctrl_mult_ovr = m[`CTRL_MULT_OVR];
					n.ctrl_mult = m[`CTRL_MULT_LSB +: `MULT_W];
					soft_go = s.wstrb[1] && s.wdata[`CTRL_SOFT_BIT];
				end
				`REG_CR0: n.cr0[31:0] = merge32(s.cr0[31:0], s.wdata, s.wstrb);
				`REG_FPU_CWSW: n.fpu_cw = 16'(merge32({16'h0, s.fpu_cw}, s.wdata, s.wstrb));
				`REG_SYSTEM_MGMT_BASE_ADDRESS: n.system_mgmt_base_address = merge32(s.system_mgmt_base_address, s.wdata, s.wstrb);
				`REG_TPR: n.tpr[31:0] = merge32(s.tpr[31:0], s.wdata, s.wstrb);
				`REG_WIN_SEL: n.win_sel = 6'(merge32({26'h0, s.win_sel}, s.wdata, s.wstrb));
				`REG_CS_SEL:
				begin
					n.cs_sel = 16'(merge32({16'h0, s.cs_sel}, s.wdata, s.wstrb));
					n.cs_base = {44'h0, n.cs_sel, 4'h0};
				end
				`REG_WIN_DATA:
				begin
					m = merge32(win_read(s), s.wdata, s.wstrb);
					if (k < `WIN_FPR)
						n.gpr[k[3:0]][31:0] = m;
					else if (k < `WIN_XMM)
						n.fpr[3'(k - `WIN_FPR)][31:0] = m;
					else if (k < `WIN_DR)
						n.xmm[4'(k - `WIN_XMM)][31:0] = m;
					else if (k < `WIN_CR2)
						n.dr[2'(k - `WIN_DR)][31:0] = m;
					else if (k == `WIN_CR2)
						n.cr2[31:0] = m;
					else if (k == `WIN_CR3)
						n.cr3[31:0] = m;
					else if (k == `WIN_CR4)
						n.cr4[31:0] = m;
					else if (k == `WIN_EXTENDED_FEATURE_REG)
						n.extended_feature_reg[31:0] = m;
				end
				default:
				begin
				end
			endcase
		end
		if (s.rvalid && rready)
			n.rvalid = 1'b0;
		if (ar_take)
		begin
			rd = reg_read(s, {araddr[7:2], 2'h0});
			n.rvalid = 1'b1;
			n.rdata = rd[31:0];
			n.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end
		unique case (s.seq)
			ST_HW_RESET:
			begin
				n.mult_strap = s.mult_s2;
				if (s.hw_s2)
				begin
					n.seq = s.ctrl_st_en ? ST_SELFTEST : ST_RUN;
					n.cache_inv = 1'b1;
					n.tlb_inv = 1'b1;
				end
			end
			ST_SELFTEST:
				if (st_bus.done)
				begin
					n.gpr[`IDX_ACC] = {60'h0, st_bus.fail};
					n.st_ran = 1'b1;
					n.seq = ST_RUN;
				end
			ST_RUN:
				if (soft_edge || soft_go)
					n = soft_init(n);
		endcase
		if (!s.hw_s2)
		begin
			n = hw_init(n);
			n.mult_strap = s.mult_s2;
			n.seq = ST_HW_RESET;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= reset_state();
		else if (ce)
			s <= n;
	end
endmodule

// ---- verification/sys_init_model.sv ----
// Model of the system logic that drives reset, initialization and straps
`timescale 1ns/100ps
module sys_init_model (
	input  wire logic       aclk,
	input  wire logic       init_busy,
	output logic            hw_reset_n,
	output logic            soft_init_req,
	output logic [3:0]      clk_mult_strap,
	output logic [3:0]      array_fault
);
	initial
	begin
		hw_reset_n = 1'h1;
		soft_init_req = 1'h0;
		clk_mult_strap = 4'h5;
		array_fault = 4'h0;
	end
	// Hold off until the core reports its reset state settled
	task automatic wait_ready();
		do
			@(posedge aclk);
		while (init_busy);
	endtask
	task automatic hw_reset(input logic [3:0] s, input logic [3:0] f);
		@(posedge aclk);
		hw_reset_n <= 1'h0;
		clk_mult_strap <= s;
		array_fault <= f;
		repeat (4) @(posedge aclk);
		hw_reset_n <= 1'h1;
		wait_ready();
		array_fault <= 4'h0;
	endtask
	task automatic soft_init();
		@(posedge aclk);
		soft_init_req <= 1'h1;
		repeat (3) @(posedge aclk);
		soft_init_req <= 1'h0;
		repeat (3) @(posedge aclk);
	endtask
endmodule

// ---- verification/init_state_checker.sv ----
// Port-level assertions for the reset and initialization sequencer
`timescale 1ns/100ps
module init_state_checker #(
	parameter int GROUP_CYCLES = 4
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       bvalid,
	input  wire logic                       bready,
	input  wire logic                       rvalid,
	input  wire logic                       rready,
	input  wire reset_init_pkg::axi_resp_t  bresp,
	input  wire logic                       init_busy,
	input  wire logic                       selftest_running,
	input  wire logic                       cache_invalidate,
	input  wire logic                       tlb_invalidate,
	input  wire logic                       apic_enable
);
	import reset_init_pkg::*;
	int unsigned run_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Length of the current self-test run
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !selftest_running)
			run_q <= 0;
		else
			run_q <= run_q + 1;
	end
	a_pulse_pair: assert property (cache_invalidate == tlb_invalidate)
		else $error("invalidate pulses differ");
	a_pulse_single: assert property (cache_invalidate |=> !cache_invalidate)
		else $error("invalidate pulse too long");
	a_pulse_cause: assert property (cache_invalidate |-> $past(init_busy))
		else $error("invalidate outside hardware reset");
	a_test_start: assert property (
		$rose(selftest_running) |-> cache_invalidate && $past(init_busy))
		else $error("self-test started outside hardware reset");
	a_test_busy: assert property (selftest_running |-> init_busy)
		else $error("busy low during self-test");
	a_test_length: assert property ($fell(selftest_running) && !init_busy
		|-> run_q >= 4 * GROUP_CYCLES && run_q <= 4 * GROUP_CYCLES + 3)
		else $error("self-test length wrong");
	a_apic_kept: assert property (apic_enable)
		else $error("interrupt controller disabled");
	a_write_once: assert property (bvalid && bready |=> !bvalid)
		else $error("write answered twice");
	a_read_once: assert property (rvalid && rready |=> !rvalid)
		else $error("read answered twice");
	c_test: cover property ($rose(selftest_running));
	c_ready: cover property ($fell(init_busy));
	c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
endmodule
bind processor_reset_init_state init_state_checker #(.GROUP_CYCLES(GROUP_CYCLES)) checker_inst (
	.aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .bready(bready), .rvalid(rvalid),
	.rready(rready), .bresp(bresp), .init_busy(init_busy), .selftest_running(selftest_running),
	.cache_invalidate(cache_invalidate), .tlb_invalidate(tlb_invalidate),
	.apic_enable(apic_enable));

// ---- verification/tb_processor_reset_init_state.sv ----
// Self-checking bench for the reset and initialization sequencer
`timescale 1ns/100ps
module tb_processor_reset_init_state;
	import reset_init_pkg::*;
	localparam int GC = 4;
	localparam logic [31:0] IDENT = {4'h0, 8'h01, 4'h2, 4'h0, 4'h3, 4'h4, 4'h5};
	logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
	logic        hw_reset_n, soft_init_req, busy, st_run, cinv, apic;
	logic [3:0]  strap, fault, core_mult, wstrb = 4'hF;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	axi_resp_t   bresp, rresp;
	int          fails = 0, checked = 0, cycles = 0, runs = 0, pulses = 0;
	processor_reset_init_state #(.GROUP_CYCLES(GC)) processor_reset_init_state_inst (
		.aclk(aclk), .aresetn(aresetn), .ce(ce), .hw_reset_n(hw_reset_n),
		.soft_init_req(soft_init_req), .clk_mult_strap(strap), .array_fault(fault),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.core_clk_mult(core_mult), .init_busy(busy), .selftest_running(st_run),
		.cache_invalidate(cinv), .tlb_invalidate(), .apic_enable(apic));
	sys_init_model sys_init_model_inst (.aclk(aclk), .init_busy(busy), .hw_reset_n(hw_reset_n),
		.soft_init_req(soft_init_req), .clk_mult_strap(strap), .array_fault(fault));
	always #5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cycles++;
		runs += st_run;
		pulses += cinv;
		if (cycles == 20000)
		begin
			fails++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input axi_resp_t er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end
		while (!bvalid);
		chk(bresp, er, "write response");
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output axi_resp_t r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'h0;
		end
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		axi_resp_t   r;
		rd(a, d, r);
		chk(d, exp, $sformatf("read %h", a));
		chk(r, RESP_OKAY, "read response");
	endtask
	task automatic t_reset_values();
		logic [7:0]  a [16];
		logic [31:0] e [16];
		a = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
			8'h34, 8'h38, 8'h44, 8'h48, 8'h4C};
		e = '{32'h6000_0010, 32'h0, IDENT, 32'h40, 32'h5555, 32'h0003_0000, 32'hF000,
			32'hFFFF_0000, 32'hFFF0, 32'h2, 32'hFFFF_0FF0, 32'h400, 32'h1F80, 32'h0092_009A,
			32'h0083_0082, 32'h0};
		for (int i = 0; i < 6; i++)
			rc(a[i], e[i]);
		for (int i = 6; i < 16; i++)
			rc(a[i], e[i]);
		rc(8'h04, 32'h0000_051C);
		chk(pulses, 1, "invalidate count");
		chk(apic, 1'h1, "interrupt controller enabled");
		chk(runs >= 4 * GC, 1, "self-test length");
		chk(core_mult, 4'h5, "strap multiple");
	endtask
	task automatic t_soft_init();
		int r0;
		r0 = runs;
		wr(8'h08, 32'h2000_0005, RESP_OKAY);
		wr(8'h14, 32'h037F, RESP_OKAY);
		wr(8'h1C, 32'h0004_0000, RESP_OKAY);
		wr(8'h4C, 32'h5, RESP_OKAY);
		wr(8'h50, 32'h1, RESP_OKAY);
		wr(8'h54, 32'hDEAD_0001, RESP_OKAY);
		wr(8'h20, 32'h1234, RESP_OKAY);
		rc(8'h24, 32'h0001_2340);
		sys_init_model_inst.soft_init();
		rc(8'h08, 32'h2000_0010);
		rc(8'h14, 32'h037F);
		rc(8'h1C, 32'h0004_0000);
		rc(8'h4C, 32'h5);
		rc(8'h20, 32'hF000);
		rc(8'h24, 32'hFFFF_0000);
		rc(8'h54, 32'h0);
		rc(8'h10, IDENT);
		rc(8'h44, 32'h0092_009A);
		chk(pulses, 1, "invalidate on soft");
		chk(runs, r0, "self-test on soft");
		chk(apic, 1'h1, "interrupt controller kept");
	endtask
	task automatic t_ctrl_soft();
		logic [31:0] t0, t1;
		axi_resp_t   r;
		wr(8'h08, 32'h0, RESP_OKAY);
		rd(8'h3C, t0, r);
		wr(8'h00, 32'h0193, RESP_OKAY);
		rc(8'h08, 32'h10);
		rd(8'h3C, t1, r);
		chk(t1 > t0, 1, "counter kept");
		chk(core_mult, 4'h9, "override multiple");
		wr(8'h00, 32'h1, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(core_mult, 4'h5, "strap restored");
		rd(8'h3C, t0, r);
		ce <= 1'h0;
		repeat (5) @(posedge aclk);
		ce <= 1'h1;
		rd(8'h3C, t1, r);
		chk(t1 - t0, 32'h3, "counter frozen while disabled");
	endtask
	task automatic t_bus_errors();
		logic [31:0] d;
		axi_resp_t   r;
		rd(8'hFC, d, r);
		chk(d, 32'h0, "unmapped data");
		chk(r, RESP_SLVERR, "unmapped read");
		wr(8'hFC, 32'h1, RESP_SLVERR);
		wr(8'h0C, 32'h1234, RESP_OKAY);
		rc(8'h0C, 32'h0);
	endtask
	task automatic t_fault_reset();
		int r0;
		sys_init_model_inst.hw_reset(4'h7, 4'h4);
		rc(8'h0C, 32'h4);
		rc(8'h08, 32'h6000_0010);
		rc(8'h14, 32'h40);
		rc(8'h1C, 32'h0003_0000);
		rc(8'h4C, 32'h0);
		chk(pulses, 2, "invalidate on hardware reset");
		chk(core_mult, 4'h7, "new strap");
		wr(8'h00, 32'h0, RESP_OKAY);
		r0 = runs;
		sys_init_model_inst.hw_reset(4'h5, 4'hF);
		rc(8'h0C, 32'h0);
		chk(runs, r0, "self-test while disabled");
		chk(pulses, 3, "invalidate without self-test");
	endtask
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		sys_init_model_inst.wait_ready();
		t_reset_values();
		t_soft_init();
		t_ctrl_soft();
		t_bus_errors();
		t_fault_reset();
		report_and_stop();
	end
endmodule
